// >>> rtl/lgtile_pkg.sv
// constants and types for the configurable logic tile
package lgtile_pkg;
    // ==========================================================
    // configuration layout
    localparam int LGTILE_NUM_IN = 4;
    localparam int LGTILE_LUT_W = 8;
    localparam logic [7:0] LGTILE_LUT_RST = 8'h00;
    localparam logic [3:0] LGTILE_INV_RST = 4'h0;
    localparam logic LGTILE_STORE_RST = 1'b0;
    localparam logic LGTILE_PRESET_VAL = 1'b1;
    localparam logic LGTILE_CLEAR_VAL = 1'b0;

    typedef enum logic [1:0] {
        LGTILE_MODE_COMB,
        LGTILE_MODE_LATCH,
        LGTILE_MODE_DFF,
        LGTILE_MODE_EDFF
    } lgtile_mode_t;
endpackage : lgtile_pkg

// >>> rtl/lgtile_cell.sv
// configurable four-input logic tile
`timescale 1ns/1ps
`default_nettype none
module lgtile_cell
    import lgtile_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // configuration
    input wire lgtile_mode_t cfg_mode_i,
    input wire logic [LGTILE_LUT_W-1:0] cfg_lut_i,
    input wire logic [LGTILE_NUM_IN-1:0] cfg_invert_i,
    input wire logic cfg_preset_i,
    // data inputs; bit 3 arrives over the global_network
    input wire logic [LGTILE_NUM_IN-1:0] tile_in_i,
    // output taps
    output logic local_output_o,
    output logic long_line_output_o
);
    // ==========================================================
    // input inversion
    logic [LGTILE_NUM_IN-1:0] in_eff;
    genvar gi;
    generate
        for (gi = 0; gi < LGTILE_NUM_IN; gi++) begin : g_inv
            assign in_eff[gi] = tile_in_i[gi] ^ cfg_invert_i[gi];
        end
    endgenerate

    // ==========================================================
    // function selection
    logic lut_out;
    logic ctl_active;
    logic data_in;
    logic enable;
    logic store_q;
    logic next_store;
    logic force_val;
    logic tile_out;

    // mode decides the role of each input
    always_comb begin
        lut_out = cfg_lut_i[in_eff[2:0]];
        data_in = in_eff[0];
        enable = 1'b1;
        ctl_active = 1'b0;
        force_val = cfg_preset_i ? LGTILE_PRESET_VAL : LGTILE_CLEAR_VAL;
        case (cfg_mode_i)
            LGTILE_MODE_LATCH: begin
                enable = in_eff[1];
                ctl_active = in_eff[2];
            end
            LGTILE_MODE_DFF: begin
                ctl_active = in_eff[2];
            end
            LGTILE_MODE_EDFF: begin
                enable = in_eff[1];
                ctl_active = in_eff[3];
            end
            default: begin
                ctl_active = 1'b0;
            end
        endcase
    end

    // clocked state; clear/set acts on the output at once in latch and flip-flop modes, not in COMB
    always_comb begin
        next_store = store_q;
        if (ctl_active) begin
            next_store = force_val;
        end else if (cfg_mode_i == LGTILE_MODE_LATCH) begin
            next_store = enable ? data_in : store_q;
        end else if (enable) begin
            next_store = data_in;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            store_q <= LGTILE_STORE_RST;
        end else begin
            store_q <= next_store;
        end
    end

    // latch is transparent while its gate is open; clear/set overrides
    always_comb begin
        case (cfg_mode_i)
            LGTILE_MODE_COMB: tile_out = lut_out;
            LGTILE_MODE_LATCH: tile_out = ctl_active ? force_val :
                (enable ? data_in : store_q);
            default: tile_out = ctl_active ? force_val : store_q;
        endcase
    end

    assign local_output_o = tile_out;
    assign long_line_output_o = tile_out;

    // ==========================================================
    // checks
    // view of the inputs after inversion, kept apart from the datapath
    logic [LGTILE_NUM_IN-1:0] chk_in;
    logic chk_force;

    assign chk_in = tile_in_i ^ cfg_invert_i;
    assign chk_force = cfg_preset_i ? LGTILE_PRESET_VAL : LGTILE_CLEAR_VAL;

    default clocking chk_cb @(posedge clk_sys_i);
    endclocking

    default disable iff (!rstn_i);

    // ==========================================================
    // flip-flop steps
    // data path free, control low
    sequence s_dff_free;
        cfg_mode_i == LGTILE_MODE_DFF && !chk_in[2];
    endsequence

    // control high
    sequence s_dff_ctl;
        cfg_mode_i == LGTILE_MODE_DFF && chk_in[2];
    endsequence

    dff_capture_a: assert property (
        s_dff_free ##1 s_dff_free |-> local_output_o == $past(chk_in[0]))
        else $error("flip-flop missed its data");

    dff_ctl_load_a: assert property (
        s_dff_ctl ##1 s_dff_free |-> local_output_o == $past(chk_force))
        else $error("flip-flop did not keep the forced value");

    // ==========================================================
    // enable flip-flop steps
    // enable low, control low
    sequence s_edff_idle;
        cfg_mode_i == LGTILE_MODE_EDFF && !chk_in[1] && !chk_in[3];
    endsequence

    // enable high, control low
    sequence s_edff_load;
        cfg_mode_i == LGTILE_MODE_EDFF && chk_in[1] && !chk_in[3];
    endsequence

    // control low, enable either way
    sequence s_edff_quiet;
        cfg_mode_i == LGTILE_MODE_EDFF && !chk_in[3];
    endsequence

    // control high on the fourth input
    sequence s_edff_ctl;
        cfg_mode_i == LGTILE_MODE_EDFF && chk_in[3];
    endsequence

    edff_hold_a: assert property (
        s_edff_idle ##1 s_edff_quiet |-> $stable(local_output_o))
        else $error("enable flip-flop changed while disabled");

    edff_load_a: assert property (
        s_edff_load ##1 s_edff_quiet |-> local_output_o == $past(chk_in[0]))
        else $error("enable flip-flop missed its data");

    edff_ctl_src_a: assert property (
        s_edff_ctl |-> local_output_o == chk_force)
        else $error("enable flip-flop control not from fourth input");

    // ==========================================================
    // latch steps
    // gate open, control low
    sequence s_latch_open;
        cfg_mode_i == LGTILE_MODE_LATCH && chk_in[1] && !chk_in[2];
    endsequence

    // gate shut, control low
    sequence s_latch_shut;
        cfg_mode_i == LGTILE_MODE_LATCH && !chk_in[1] && !chk_in[2];
    endsequence

    latch_open_a: assert property (
        s_latch_open |-> local_output_o == chk_in[0])
        else $error("open latch not transparent");

    latch_hold_a: assert property (
        s_latch_open ##1 s_latch_shut |-> local_output_o == $past(chk_in[0]))
        else $error("shut latch lost its value");

    // ==========================================================
    // shared checks
    ctl_force_a: assert property (
        (cfg_mode_i == LGTILE_MODE_LATCH || cfg_mode_i == LGTILE_MODE_DFF)
        && chk_in[2] |-> local_output_o == chk_force)
        else $error("clear or set did not override");

    lut_out_a: assert property (
        cfg_mode_i == LGTILE_MODE_COMB
        |-> local_output_o == cfg_lut_i[tile_in_i[2:0] ^ cfg_invert_i[2:0]])
        else $error("lookup output wrong");

    invert_a: assert property (
        cfg_mode_i == LGTILE_MODE_COMB && cfg_invert_i[0]
        |-> local_output_o == cfg_lut_i[{chk_in[2:1], ~tile_in_i[0]}])
        else $error("inversion wrong");

    taps_equal_a: assert property (
        local_output_o == long_line_output_o)
        else $error("output taps differ");

    // ==========================================================
    // limits
    // clear/set is modelled as an output override plus a load of the
    // forced value at the next edge; a pulse that spans no rising clock
    // edge shows on the taps but is not kept in the stored bit.
    // the fourth input is meant for the global_network only; the cell
    // does not police where it comes from.
endmodule : lgtile_cell
`default_nettype wire

// >>> bench/lgtile_nbr.sv
// neighbouring user cells feeding the tile and watching both taps
`timescale 1ns/1ps
`default_nettype none
module lgtile_nbr (
    // drive request from the bench
    input wire logic [3:0] req_i,
    // tile side
    output logic [3:0] tile_in_o,
    input wire logic local_i,
    input wire logic long_i,
    output logic [1:0] seen_o
);
    assign tile_in_o = req_i;
    assign seen_o = {long_i, local_i};
endmodule : lgtile_nbr
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the logic tile
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lgtile_pkg::*;
    logic clk_sys_i = 0, rstn_i = 0, pre = 0, loc, lng;
    lgtile_mode_t mode = LGTILE_MODE_COMB;
    logic [7:0] lut = 8'h00;
    logic [3:0] inv = 4'h0, req = 4'h0, tin;
    logic [1:0] seen;
    int err_total = 0, samples_checked = 0;
    always #2 clk_sys_i = ~clk_sys_i;
    lgtile_cell u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .cfg_mode_i(mode), .cfg_lut_i(lut), .cfg_invert_i(inv),
        .cfg_preset_i(pre), .tile_in_i(tin), .local_output_o(loc),
        .long_line_output_o(lng));
    lgtile_nbr u_nbr (.req_i(req), .tile_in_o(tin), .local_i(loc),
        .long_i(lng), .seen_o(seen));
    // ==========================================
    // helpers
    task automatic chk(input string nm, input logic [1:0] s, input logic e);
        samples_checked++;
        if (s !== {e, e}) begin
            err_total++;
            $display("unexpected %s exp %b got %b", nm, e, s);
        end
    endtask : chk
    task automatic cfg(input lgtile_mode_t m, input logic p);
        @(posedge clk_sys_i);
        mode <= m;
        pre <= p;
    endtask : cfg
    task automatic sc(input logic [3:0] v, input logic e);
        @(posedge clk_sys_i);
        req <= v;
        @(negedge clk_sys_i);
        chk("tap", seen, e);
    endtask : sc
    task automatic t_comb();
        logic [7:0] l;
        logic [3:0] n;
        for (int k = 0; k < 2; k++) begin
            l = (k == 0) ? 8'hC4 : 8'h6B;
            n = (k == 0) ? 4'h0 : 4'h5;
            cfg(LGTILE_MODE_COMB, 1'b0);
            lut <= l;
            inv <= n;
            for (int i = 0; i < 8; i++) begin
                sc(4'(i), l[3'(i) ^ n[2:0]]);
            end
        end
        inv <= 4'h0;
    endtask : t_comb
    task automatic t_dff();
        cfg(LGTILE_MODE_DFF, 1'b0);
        sc(4'h0, 1'b0);
        sc(4'h1, 1'b0);
        sc(4'h1, 1'b1);
        sc(4'h5, 1'b0);
        sc(4'h1, 1'b0);
        sc(4'h0, 1'b1);
        cfg(LGTILE_MODE_DFF, 1'b1);
        sc(4'h0, 1'b0);
        sc(4'h4, 1'b1);
    endtask : t_dff
    task automatic t_edff();
        cfg(LGTILE_MODE_EDFF, 1'b0);
        sc(4'h3, 1'b1);
        sc(4'h0, 1'b1);
        sc(4'h0, 1'b1);
        sc(4'hB, 1'b0);
        sc(4'h3, 1'b0);
        sc(4'h3, 1'b1);
    endtask : t_edff
    task automatic t_latch();
        cfg(LGTILE_MODE_LATCH, 1'b1);
        sc(4'h3, 1'b1);
        sc(4'h2, 1'b0);
        sc(4'h1, 1'b0);
        sc(4'h5, 1'b1);
    endtask : t_latch
    task automatic t_inv_ctl();
        cfg(LGTILE_MODE_EDFF, 1'b0);
        inv <= 4'h8;
        sc(4'h3, 1'b0);
        sc(4'hB, 1'b0);
        sc(4'hB, 1'b1);
        sc(4'h0, 1'b0);
        cfg(LGTILE_MODE_LATCH, 1'b0);
        inv <= 4'h0;
        sc(4'h3, 1'b1);
        sc(4'h7, 1'b0);
        sc(4'h1, 1'b0);
    endtask : t_inv_ctl
    task automatic wrap_up();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_comb();
        t_dff();
        t_edff();
        t_latch();
        t_inv_ctl();
        wrap_up();
    end
    initial begin
        #4000;
        err_total++;
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
